// ===== common/lcdc_pkg.sv
// Shared constants, command codes, drive levels and helpers for the LCD command unit
package lcdc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PAGE_W = 2;
  localparam int COL_W = 7;
  localparam int START_W = 5;
  localparam int NUM_PAGES = 4;
  localparam int NUM_COLS = 80;
  localparam int MEM_BYTES = NUM_PAGES * NUM_COLS;
  localparam int IDX_W = 9;
  localparam int NUM_SEGS = 61;
  localparam int NUM_COMS = 16;
  localparam int COM_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W = DATA_W + 1;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RMW_ENTER = 8'hE0;
  localparam logic [7:0] CMD_RMW_EXIT = 8'hEE;
  localparam logic [7:0] CMD_SW_RESET = 8'hE2;

  // Register select codes of the side load port
  localparam logic [1:0] SEL_PAGE = 2'h0;
  localparam logic [1:0] SEL_COL = 2'h1;
  localparam logic [1:0] SEL_START = 2'h2;
  localparam logic [1:0] SEL_DISP = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PAGE_RST = 2'h0;
  localparam logic [1:0] PAGE_SWRST = 2'h3;
  localparam logic [6:0] COL_RST = 7'h00;
  localparam logic [4:0] START_RST = 5'h00;
  localparam logic DISP_ON_RST = 1'b0;
  localparam logic [7:0] LATCH_RST = 8'h00;

  // ----------------------------------------------------------------
  // Drive level codes
  // ----------------------------------------------------------------
  localparam int LV_W = 3;
  localparam logic [2:0] LV_VDD = 3'h0;
  localparam logic [2:0] LV_V1 = 3'h1;
  localparam logic [2:0] LV_V2 = 3'h2;
  localparam logic [2:0] LV_V3 = 3'h3;
  localparam logic [2:0] LV_V4 = 3'h4;
  localparam logic [2:0] LV_V5 = 3'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int EXEC_NS = 200;
  localparam int EXEC_CYCLES = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_BUSY_NS = 1000;
  localparam int RESET_BUSY_CYCLES = (RESET_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;

  // Byte index of a page/column pair
  function automatic logic [IDX_W-1:0] mem_index(logic [1:0] page, logic [6:0] col);
    return IDX_W'(page) * IDX_W'(NUM_COLS) + IDX_W'(col);
  endfunction : mem_index

  // Column step with wrap after the last column
  function automatic logic [6:0] col_inc(logic [6:0] col);
    return (col == 7'(NUM_COLS - 1)) ? 7'h00 : col + 7'h01;
  endfunction : col_inc

endpackage : lcdc_pkg

// ===== common/lcdc_stream_if.sv
// Valid/ready word stream between the command unit and its queue
`timescale 1ns/1ps
interface lcdc_stream_if #(parameter int WIDTH = 9) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : lcdc_stream_if

// ===== design/lcdc_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lcdc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Fill and drain sides
  lcdc_stream_if.snk push_if,
  lcdc_stream_if.src pop_if
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  wire push_fire = push_if.valid & push_if.ready;
  wire pop_fire = pop_if.valid & pop_if.ready;

  // Full and empty flags
  assign push_if.ready = (count_reg != CW'(DEPTH));
  assign pop_if.valid = (count_reg != '0);
  assign pop_if.data = store[rd_ptr_reg];

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push_fire) begin
      store[wr_ptr_reg] <= push_if.data;
    end
  end

  // Pointers wrap naturally; depth is a power of two
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push_fire);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop_fire);
      count_reg <= count_reg + CW'(push_fire) - CW'(pop_fire);
    end
  end

  a_fifo_fill_count: assert property (@(posedge clk_i) disable iff (reset_i)
    push_fire && !pop_fire |=> count_reg == $past(count_reg) + CW'(1))
    else $error("fifo count did not grow on push");
  a_fifo_full_stop: assert property (@(posedge clk_i) disable iff (reset_i)
    count_reg == CW'(DEPTH) |-> !push_if.ready)
    else $error("fifo accepts while full");

endmodule : lcdc_fifo

// ===== design/lcdc_level_sel.sv
// Maps frame polarity and per-line data to segment or common drive levels
`timescale 1ns/1ps
module lcdc_level_sel
  import lcdc_pkg::*;
#(
  parameter int N = 61,
  parameter bit IS_COMMON = 1'b0
) (
  // Inputs
  input wire logic frame_i,
  input wire logic [N-1:0] data_i,
  // Levels with the display on
  output logic [N-1:0][LV_W-1:0] level_o
);

  // Level table for one line
  function automatic logic [LV_W-1:0] pick(logic fp, logic d);
    logic [LV_W-1:0] lv;
    lv = LV_VDD;
    if (IS_COMMON) begin
      unique case ({fp, d})
        2'b00: lv = LV_V4;
        2'b01: lv = LV_VDD;
        2'b10: lv = LV_V1;
        2'b11: lv = LV_V5;
      endcase
    end else begin
      unique case ({fp, d})
        2'b00: lv = LV_V3;
        2'b01: lv = LV_V5;
        2'b10: lv = LV_V2;
        2'b11: lv = LV_VDD;
      endcase
    end
    return lv;
  endfunction : pick

  // One selector per line
  for (genvar i = 0; i < N; i++) begin : g_line
    assign level_o[i] = pick(frame_i, data_i[i]);
  end

endmodule : lcdc_level_sel

// ===== design/lcdc_cmd_unit.sv
// LCD display memory command unit: host bus, queue, memory, read latch, drive levels
//
// Summary of operation
// RULE1 - Data write stores byte, column steps
// RULE2 - Host writes with select high, write
// RULE3 - Read returns previous output latch byte
// RULE4 - Then latch loads addressed memory byte
// RULE5 - Normal read steps column afterwards
// RULE6 - Host discards one dummy read first
// RULE7 - Writes go straight into memory
// RULE8 - Host reads with select high, read
// RULE9 - E0 enters modify mode, saves column
// RULE10 - Modify mode: reads hold, writes step
// RULE11 - EE leaves modify mode, restores column
// RULE12 - Modify mode still loads other registers
// RULE13 - Host sends commands with select low
// RULE14 - E2 clears start line register
// RULE15 - E2 sets page register to three
// RULE16 - E2 keeps memory and other registers
// RULE17 - E2 is not a hardware reset
// RULE18 - Segment level from frame, data, on
// RULE19 - Common level from counter; off holds
// RULE20 - During reset all outputs at supply
// RULE21 - Busy during reset or full; host waits
// RULE22 - Unknown command codes change nothing
`timescale 1ns/1ps
module lcdc_cmd_unit
  import lcdc_pkg::*;
#(
  parameter int QUEUE_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Host bus pins
  input wire logic chip_sel_n_i,
  input wire logic cmd_data_i,
  input wire logic enable_read_i,
  input wire logic read_write_i,
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_n_o,
  // Register loads from the neighbouring decoder
  input wire logic reg_wr_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [7:0] reg_val_i,
  // Scan timing
  input wire logic scan_tick_i,
  // Status
  output logic busy_o,
  output logic idle_o,
  output logic rmw_mode_o,
  // Panel drive
  output logic frame_polarity_o,
  output logic [NUM_SEGS-1:0][LV_W-1:0] segment_outputs_o,
  output logic [NUM_COMS-1:0][LV_W-1:0] common_outputs_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = 12;
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic pin_cs_prev_reg;

  // Two stages, then a history bit for the select edge
  always_ff @(posedge clk_i) begin
    pin_s1_reg <= {chip_sel_n_i, cmd_data_i, enable_read_i, read_write_i, host_data_bus_i};
    pin_s2_reg <= pin_s1_reg;
    pin_cs_prev_reg <= pin_s2_reg[11];
  end

  // Decoded host strobes
  wire sel_n = pin_s2_reg[11];
  wire pin_cd = pin_s2_reg[10];
  wire pin_e = pin_s2_reg[9];
  wire pin_rw = pin_s2_reg[8];
  wire [7:0] pin_byte = pin_s2_reg[7:0];
  wire take = pin_cs_prev_reg & ~sel_n;
  wire is_wr = pin_e & ~pin_rw; // RULE2 RULE13
  wire is_rd = ~pin_e & pin_rw & pin_cd; // RULE8

  // ----------------------------------------------------------------
  // Queue between host and engine
  // ----------------------------------------------------------------
  lcdc_stream_if #(.WIDTH(WORD_W)) push_bus ();
  lcdc_stream_if #(.WIDTH(WORD_W)) pop_bus ();

  lcdc_fifo #(.WIDTH(WORD_W), .DEPTH(QUEUE_DEPTH)) u_queue (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .push_if(push_bus),
    .pop_if(pop_bus)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mem [0:MEM_BYTES-1];
  logic [1:0] page_reg;
  logic [6:0] col_reg;
  logic [6:0] col_next;
  logic [6:0] saved_col_reg;
  logic [4:0] start_reg;
  logic disp_on_reg;
  logic rmw_reg;
  logic [7:0] latch_reg;
  logic [7:0] bus_out_reg;
  logic oe_n_reg;
  logic [CNT_W-1:0] exec_cnt_reg;
  logic [CNT_W-1:0] rst_cnt_reg;
  logic [COM_W-1:0] com_cnt_reg;
  logic frame_reg;
  logic [NUM_SEGS-1:0][LV_W-1:0] seg_out_reg;
  logic [NUM_COMS-1:0][LV_W-1:0] com_out_reg;

  // ----------------------------------------------------------------
  // Engine decode
  // ----------------------------------------------------------------
  wire resetting = (rst_cnt_reg != '0);
  wire exec_idle = (exec_cnt_reg == '0);
  wire engine_idle = exec_idle & ~pop_bus.valid & ~resetting;
  wire wr_take = take & is_wr;
  wire rd_take = take & is_rd & engine_idle;
  wire pop_fire = pop_bus.valid & pop_bus.ready;
  wire pop_cd = pop_bus.data[8];
  wire [7:0] pop_byte = pop_bus.data[7:0];
  wire do_wr_data = pop_fire & pop_cd;
  wire do_cmd = pop_fire & ~pop_cd;
  wire cmd_rmw_on = do_cmd & (pop_byte == CMD_RMW_ENTER);
  wire cmd_rmw_off = do_cmd & (pop_byte == CMD_RMW_EXIT) & rmw_reg;
  wire cmd_swrst = do_cmd & (pop_byte == CMD_SW_RESET);
  wire cmd_unknown = do_cmd & ~cmd_rmw_on & ~cmd_rmw_off & ~cmd_swrst; // RULE22
  wire [IDX_W-1:0] cur_idx = mem_index(page_reg, col_reg);
  wire [7:0] rd_byte = mem[cur_idx];
  wire side_ok = reg_wr_i & ~pop_fire & ~rd_take;
  wire ld_page = side_ok & (reg_sel_i == SEL_PAGE); // RULE12
  wire ld_col = side_ok & (reg_sel_i == SEL_COL) & ~rmw_reg & (reg_val_i[6:0] < 7'(NUM_COLS));
  wire ld_start = side_ok & (reg_sel_i == SEL_START);
  wire ld_disp = side_ok & (reg_sel_i == SEL_DISP);

  // Queue hookup: host pushes, engine drains one word per execution
  assign push_bus.valid = wr_take;
  assign push_bus.data = {pin_cd, pin_byte};
  assign pop_bus.ready = exec_idle & ~resetting;

  // Status pins
  assign busy_o = resetting | ~push_bus.ready; // RULE21
  assign idle_o = engine_idle;
  assign rmw_mode_o = rmw_reg;

  // ----------------------------------------------------------------
  // Column address
  // ----------------------------------------------------------------
  always_comb begin
    col_next = col_reg;
    if (do_wr_data) begin
      col_next = col_inc(col_reg); // RULE1 RULE10
    end else if (rd_take && !rmw_reg) begin
      col_next = col_inc(col_reg); // RULE5 RULE10
    end else if (cmd_rmw_off) begin
      col_next = saved_col_reg; // RULE11
    end else if (ld_col) begin
      col_next = reg_val_i[6:0];
    end
  end

  // Address and mode registers; soft reset touches only start and page
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      col_reg <= COL_RST;
      saved_col_reg <= COL_RST;
      page_reg <= PAGE_RST;
      start_reg <= START_RST;
      disp_on_reg <= DISP_ON_RST;
      rmw_reg <= 1'b0;
    end else begin
      col_reg <= col_next;
      if (cmd_rmw_on) begin
        rmw_reg <= 1'b1; // RULE9
        saved_col_reg <= col_reg; // RULE9
      end else if (cmd_rmw_off) begin
        rmw_reg <= 1'b0; // RULE11
      end
      if (cmd_swrst) begin
        page_reg <= PAGE_SWRST; // RULE15 RULE16 RULE17
        start_reg <= START_RST; // RULE14
      end else begin
        page_reg <= ld_page ? reg_val_i[1:0] : page_reg;
        start_reg <= ld_start ? reg_val_i[4:0] : start_reg;
      end
      disp_on_reg <= ld_disp ? reg_val_i[0] : disp_on_reg;
    end
  end

  // ----------------------------------------------------------------
  // Memory and read path
  // ----------------------------------------------------------------
  // Bus byte lands in the cell with no staging
  always_ff @(posedge clk_i) begin
    if (do_wr_data) begin
      mem[cur_idx] <= pop_byte; // RULE1 RULE7
    end
  end

  // Old latch goes out, then latch refills; host drops the first read
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      latch_reg <= LATCH_RST;
      bus_out_reg <= LATCH_RST;
      oe_n_reg <= 1'b1;
    end else begin
      if (rd_take) begin
        bus_out_reg <= latch_reg; // RULE3 RULE6
        latch_reg <= rd_byte; // RULE4
      end
      oe_n_reg <= ~(~sel_n & is_rd);
    end
  end

  assign host_data_bus_o = bus_out_reg;
  assign host_data_bus_oe_n_o = oe_n_reg;

  // ----------------------------------------------------------------
  // Execution and reset timers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      exec_cnt_reg <= '0;
      rst_cnt_reg <= CNT_W'(RESET_BUSY_CYCLES);
    end else begin
      if (pop_fire) begin
        exec_cnt_reg <= CNT_W'(EXEC_CYCLES);
      end else if (!exec_idle) begin
        exec_cnt_reg <= exec_cnt_reg - CNT_W'(1);
      end
      if (resetting) begin
        rst_cnt_reg <= rst_cnt_reg - CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Scan and drive levels
  // ----------------------------------------------------------------
  logic [NUM_SEGS-1:0] seg_data;
  logic [NUM_COMS-1:0] com_data;
  logic [NUM_SEGS-1:0][LV_W-1:0] seg_lvl;
  logic [NUM_COMS-1:0][LV_W-1:0] com_lvl;
  wire [4:0] disp_row = {1'b0, com_cnt_reg} + start_reg;
  wire [1:0] row_page = disp_row[4:3];
  wire [2:0] row_bit = disp_row[2:0];
  wire [LV_W-1:0] seg_off_lvl = frame_reg ? LV_V2 : LV_V3;

  // Row bit of each visible column and the active common
  for (genvar j = 0; j < NUM_SEGS; j++) begin : g_seg
    assign seg_data[j] = mem[mem_index(row_page, 7'(j))][row_bit];
  end
  for (genvar k = 0; k < NUM_COMS; k++) begin : g_com
    assign com_data[k] = (com_cnt_reg == COM_W'(k));
  end

  lcdc_level_sel #(.N(NUM_SEGS), .IS_COMMON(1'b0)) u_seg_sel (
    .frame_i(frame_reg),
    .data_i(seg_data),
    .level_o(seg_lvl)
  );

  lcdc_level_sel #(.N(NUM_COMS), .IS_COMMON(1'b1)) u_com_sel (
    .frame_i(frame_reg),
    .data_i(com_data),
    .level_o(com_lvl)
  );

  // Common counter; frame flips once per full scan
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      com_cnt_reg <= '0;
      frame_reg <= 1'b0;
    end else if (scan_tick_i) begin
      com_cnt_reg <= com_cnt_reg + COM_W'(1);
      frame_reg <= (com_cnt_reg == COM_W'(NUM_COMS - 1)) ? ~frame_reg : frame_reg;
    end
  end

  // Registered drive; supply during reset, commons freeze when off
  always_ff @(posedge clk_i) begin
    if (reset_i || resetting) begin
      seg_out_reg <= {NUM_SEGS{LV_VDD}}; // RULE20
      com_out_reg <= {NUM_COMS{LV_VDD}}; // RULE20
    end else begin
      seg_out_reg <= disp_on_reg ? seg_lvl : {NUM_SEGS{seg_off_lvl}}; // RULE18
      com_out_reg <= disp_on_reg ? com_lvl : com_out_reg; // RULE19
    end
  end

  assign frame_polarity_o = frame_reg;
  assign segment_outputs_o = seg_out_reg;
  assign common_outputs_o = com_out_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_wr_mem_store: assert property (do_wr_data |=> mem[$past(cur_idx)] == $past(pop_byte)) // RULE7
    else $error("data write not stored");
  a_wr_col_step: assert property (do_wr_data |=> col_reg == col_inc($past(col_reg))) // RULE1
    else $error("column not stepped after write");
  a_rd_latch_out: assert property (rd_take |=> bus_out_reg == $past(latch_reg)) // RULE3
    else $error("read did not return old latch");
  a_rd_latch_load: assert property (rd_take |=> latch_reg == $past(rd_byte)) // RULE4
    else $error("latch not refilled from memory");
  a_rd_col_step: assert property (rd_take && !rmw_reg |=> col_reg == col_inc($past(col_reg))) // RULE5
    else $error("column not stepped after read");
  a_rmw_read_hold: assert property (rd_take && rmw_reg |=> $stable(col_reg)) // RULE10
    else $error("column moved on modify-mode read");
  a_rmw_enter_save: assert property (cmd_rmw_on |=> rmw_reg && saved_col_reg == $past(col_reg)) // RULE9
    else $error("modify mode entry wrong");
  a_rmw_exit_load: assert property (cmd_rmw_off |=> !rmw_reg && col_reg == $past(saved_col_reg)) // RULE11
    else $error("modify mode exit wrong");
  a_rmw_page_load: assert property (rmw_reg && ld_page |=> page_reg == $past(reg_val_i[1:0])) // RULE12
    else $error("page not loaded in modify mode");
  a_swrst_start: assert property (cmd_swrst |=> start_reg == START_RST) // RULE14
    else $error("start line not cleared");
  a_swrst_page: assert property (cmd_swrst |=> page_reg == PAGE_SWRST) // RULE15
    else $error("page not set by soft reset");
  a_swrst_keep: assert property (cmd_swrst |=> $stable(col_reg) && $stable(disp_on_reg) && $stable(rmw_reg)) // RULE16
    else $error("soft reset disturbed other state");
  a_unknown_cmd: assert property (cmd_unknown |=> $stable(col_reg) && $stable(page_reg) && $stable(start_reg)
    && $stable(rmw_reg)) // RULE22
    else $error("unknown command changed state");
  a_seg_on_level: assert property (disp_on_reg && !resetting && !frame_reg && seg_data[0]
    |=> seg_out_reg[0] == LV_V5) // RULE18
    else $error("segment level wrong");
  a_com_off_hold: assert property (!disp_on_reg && !resetting |=> $stable(com_out_reg)) // RULE19
    else $error("common level moved while off");
  a_reset_supply: assert property (resetting |=> seg_out_reg == {NUM_SEGS{LV_VDD}}) // RULE20
    else $error("outputs not at supply in reset");
  a_busy_after_reset: assert property ($fell(reset_i) |-> busy_o [*8]) // RULE21
    else $error("busy not held after reset");

  c_data_write: cover property (do_wr_data);
  c_read_pair: cover property (rd_take ##[1:100] rd_take);
  c_rmw_cycle: cover property (cmd_rmw_on ##[1:300] rd_take ##[1:300] cmd_rmw_off);
  c_soft_reset: cover property (cmd_swrst);

endmodule : lcdc_cmd_unit

// ===== test/lcdc_host_model.sv
// Host microcontroller model driving the parallel bus pins
`timescale 1ns/1ps
module lcdc_host_model (
  // Clock
  input wire logic clk_i,
  // Bus pins towards the device
  output logic chip_sel_n_o,
  output logic cmd_data_o,
  output logic enable_read_o,
  output logic read_write_o,
  output logic [7:0] data_o,
  // Bus as seen by the host
  input wire logic [7:0] data_i
);
  // Idle pins at time zero
  initial begin
    chip_sel_n_o = 1'b1;
    cmd_data_o = 1'b1;
    enable_read_o = 1'b0;
    read_write_o = 1'b1;
    data_o = 8'hA5;
  end

  // One write access, cd high for data and low for a command
  task automatic wr(input logic cd, input logic [7:0] val);
    @(posedge clk_i);
    chip_sel_n_o <= 1'b0;
    cmd_data_o <= cd;
    enable_read_o <= 1'b1;
    read_write_o <= 1'b0;
    data_o <= val;
    repeat (5) @(posedge clk_i);
    chip_sel_n_o <= 1'b1;
    data_o <= ~val; // Released bus must not keep the last byte
    repeat (4) @(posedge clk_i);
  endtask : wr

  // One display data read, byte taken while still selected
  task automatic rd(output logic [7:0] val);
    @(posedge clk_i);
    chip_sel_n_o <= 1'b0;
    cmd_data_o <= 1'b1;
    enable_read_o <= 1'b0;
    read_write_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    val = data_i;
    chip_sel_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : rd
endmodule : lcdc_host_model

// ===== test/lcdc_cmd_unit_tb.sv
// Self-checking bench for the LCD display memory command unit
`timescale 1ns/1ps
module lcdc_cmd_unit_tb;
  import lcdc_pkg::*;
  logic clk_i, reset_i, reg_wr, scan_tick, cs_n, cd, er, rw, oe_n, busy, idle, rmw, frame, in_rmw, frm, ofrm;
  logic [1:0] reg_sel;
  logic [7:0] reg_val, host_dat, dev_dat, rd_val, lat;
  logic [NUM_SEGS-1:0][LV_W-1:0] seg;
  logic [NUM_COMS-1:0][LV_W-1:0] com;
  logic [7:0] mem [MEM_BYTES];
  int fails, compares, seed, pg, cl, cnt, ocnt, saved;
  wire [7:0] bus_in = oe_n ? host_dat : dev_dat;

  lcdc_cmd_unit #(.QUEUE_DEPTH(FIFO_DEPTH)) uut (.clk_i(clk_i), .reset_i(reset_i), .chip_sel_n_i(cs_n),
    .cmd_data_i(cd), .enable_read_i(er), .read_write_i(rw), .host_data_bus_i(bus_in), .host_data_bus_o(dev_dat),
    .host_data_bus_oe_n_o(oe_n), .reg_wr_i(reg_wr), .reg_sel_i(reg_sel), .reg_val_i(reg_val),
    .scan_tick_i(scan_tick), .busy_o(busy), .idle_o(idle), .rmw_mode_o(rmw), .frame_polarity_o(frame),
    .segment_outputs_o(seg), .common_outputs_o(com));
  lcdc_host_model host (.clk_i(clk_i), .chip_sel_n_o(cs_n), .cmd_data_o(cd), .enable_read_o(er),
    .read_write_o(rw), .data_o(host_dat), .data_i(bus_in));

  // Clock generator
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Expected drive levels
  function automatic logic [2:0] seg_lv(logic f, logic d);
    return f ? (d ? LV_VDD : LV_V2) : (d ? LV_V5 : LV_V3);
  endfunction : seg_lv
  function automatic logic [2:0] com_lv(logic f, logic a);
    return f ? (a ? LV_V5 : LV_V1) : (a ? LV_VDD : LV_V4);
  endfunction : com_lv

  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Bounded wait until the unit accepts any access
  task automatic wait_idle();
    int n;
    n = 0;
    while (idle !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 200) begin
      fails++;
      $display("BAD idle expected 1 seen %b", idle);
      stop_test();
    end
  endtask : wait_idle
  task automatic put(input logic [7:0] v);
    wait_idle();
    host.wr(1'b1, v);
    mem[pg*NUM_COLS+cl] = v;
    cl = (cl + 1) % NUM_COLS;
  endtask : put
  task automatic cmd(input logic [7:0] v);
    wait_idle();
    host.wr(1'b0, v);
  endtask : cmd
  // Read returns old latch, then latch reloads and column may step
  task automatic rdchk();
    wait_idle();
    host.rd(rd_val);
    chk("read byte", lat, rd_val);
    lat = mem[pg*NUM_COLS+cl];
    if (!in_rmw) cl = (cl + 1) % NUM_COLS;
  endtask : rdchk
  task automatic setreg(input logic [1:0] s, input logic [7:0] v);
    wait_idle();
    @(posedge clk_i);
    reg_wr <= 1'b1;
    reg_sel <= s;
    reg_val <= v;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask : setreg
  task automatic tick();
    @(posedge clk_i);
    scan_tick <= 1'b1;
    @(posedge clk_i);
    scan_tick <= 1'b0;
    cnt = (cnt + 1) % NUM_COMS;
    if (cnt == 0) frm = ~frm;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask : tick

  // Main sequence
  initial begin
    seed = 84631;
    reset_i = 1'b1;
    reg_wr = 1'b0;
    reg_sel = SEL_PAGE;
    reg_val = 8'h00;
    scan_tick = 1'b0;
    lat = LATCH_RST;
    in_rmw = 1'b0;
    cnt = 0;
    frm = 1'b0;
    repeat (10) @(posedge clk_i);
    chk("seg in reset", 8'(LV_VDD), 8'(seg[5]));
    chk("com in reset", 8'(LV_VDD), 8'(com[3]));
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("busy after reset", 8'h01, 8'(busy));
    // Random fill of pages 0 and 1, then a wrapping run on page 1
    for (int p = 0; p < 3; p++) begin
      pg = (p == 0) ? 0 : 1;
      cl = (p == 2) ? 76 : 0;
      setreg(SEL_PAGE, 8'(pg));
      setreg(SEL_COL, 8'(cl));
      for (int j = 0; j < 9; j++) put(8'($random(seed)));
    end
    setreg(SEL_COL, 8'd76);
    cl = 76;
    for (int j = 0; j < 9; j++) rdchk();
    // Modify mode: reads hold column, writes step, exit restores
    setreg(SEL_PAGE, 8'h00);
    setreg(SEL_COL, 8'h02);
    pg = 0;
    cl = 2;
    cmd(CMD_RMW_ENTER);
    in_rmw = 1'b1;
    saved = cl;
    chk("modify flag on", 8'h01, 8'(rmw));
    rdchk();
    rdchk();
    put(8'($random(seed)));
    setreg(SEL_COL, 8'd40);
    setreg(SEL_PAGE, 8'h01);
    pg = 1;
    rdchk();
    cmd(CMD_RMW_EXIT);
    in_rmw = 1'b0;
    cl = saved;
    chk("modify flag off", 8'h00, 8'(rmw));
    rdchk();
    rdchk();
    // Unknown code and stray exit change nothing
    cmd(8'hA7);
    cmd(CMD_RMW_EXIT);
    chk("modify flag stray", 8'h00, 8'(rmw));
    rdchk();
    // Software reset: page to 3, start line to 0, column kept
    setreg(SEL_START, 8'h03);
    setreg(SEL_PAGE, 8'h00);
    setreg(SEL_COL, 8'd10);
    cl = 10;
    cmd(CMD_SW_RESET);
    pg = 3;
    put(8'($random(seed)));
    put(8'($random(seed)));
    setreg(SEL_COL, 8'd10);
    cl = 10;
    rdchk();
    rdchk();
    // Drive levels over two frames with start line 0
    setreg(SEL_DISP, 8'h01);
    for (int t = 0; t < 33; t++) begin
      tick();
      chk("frame", 8'(frm), 8'(frame));
      for (int i = 0; i < NUM_COMS; i++) chk("common", 8'(com_lv(frm, i == cnt)), 8'(com[i]));
      for (int j = 0; j < 8; j++) chk("segment", 8'(seg_lv(frm, mem[(cnt/8)*NUM_COLS+j][cnt%8])), 8'(seg[j]));
    end
    // Display off: commons hold, segments at V2 or V3
    ocnt = cnt;
    ofrm = frm;
    setreg(SEL_DISP, 8'h00);
    tick();
    for (int i = 0; i < NUM_COMS; i++) chk("common held", 8'(com_lv(ofrm, i == ocnt)), 8'(com[i]));
    chk("segment off", 8'(frm ? LV_V2 : LV_V3), 8'(seg[0]));
    stop_test();
  end
endmodule : lcdc_cmd_unit_tb
